// ---- hdl/tcc_regs.vh ----
/*
 * Register map, field positions, reset values and encodings for the
 * 16-bit capture/compare timer channel.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// Byte offsets of the registers
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_TOGGLE 8'h04
`define TCC_OFF_CMP_A 8'h08
`define TCC_OFF_CMP_B 8'h0C
`define TCC_OFF_CAP_A 8'h10
`define TCC_OFF_CAP_B 8'h14
`define TCC_OFF_COUNT 8'h18

// Channel mode register fields
`define TCC_CTRL_RUN 0
`define TCC_CTRL_PRE_RUN 1
`define TCC_CTRL_CLR_EN 2
`define TCC_CTRL_CLK_LO 3
`define TCC_CTRL_CLK_HI 4
`define TCC_CTRL_CAP_LO 5
`define TCC_CTRL_CAP_HI 6
`define TCC_CTRL_SOFT_CAP_N 7
`define TCC_CTRL_DB_EN 8
`define TCC_CTRL_PIN_SEL 9
`define TCC_CTRL_GPIO 10

// Toggle control register fields
`define TCC_TGL_CTL_LO 0
`define TCC_TGL_CTL_HI 1
`define TCC_TGL_EN_LO 2
`define TCC_TGL_EN_HI 5
`define TCC_TGL_SEC_CTL_LO 6
`define TCC_TGL_SEC_CTL_HI 7
`define TCC_TGL_SEC_EN_LO 8
`define TCC_TGL_SEC_EN_HI 9
`define TCC_TGL_PRI_STATE 10
`define TCC_TGL_SEC_STATE 11

// Capture timing modes
`define TCC_CAP_OFF 2'h0
`define TCC_CAP_TWO_PIN 2'h1
`define TCC_CAP_PULSE 2'h2
`define TCC_CAP_BYTE_TGL 2'h3

// Count source select
`define TCC_CLK_EXT 2'h0
`define TCC_CLK_T1 2'h1
`define TCC_CLK_T4 2'h2
`define TCC_CLK_T16 2'h3

// Toggle control actions
`define TCC_TGL_INVERT 2'h0
`define TCC_TGL_SET 2'h1
`define TCC_TGL_CLEAR 2'h2
`define TCC_TGL_KEEP 2'h3

// Prescaler tap masks (tick when masked bits all ones)
`define TCC_PRE_MASK_T1 9'h001
`define TCC_PRE_MASK_T4 9'h007
`define TCC_PRE_MASK_T16 9'h01F

// Reset values
`define TCC_RST_CMP 16'h0000
`define TCC_RST_WORD 32'h0000_0000

`endif

// ---- hdl/tcc_edge_sync.v ----
/*
 * Two-flop synchronisers with edge detection, one lane per pin.
 * Assumes pins are asynchronous levels; edges come out one cycle wide.
 */
`timescale 1ns/10ps
module tcc_edge_sync #(
	parameter W = 3
) (
	input wire i_clk,
	input wire i_rst,
	input wire [W-1:0] i_pins,
	output wire [W-1:0] o_rise,
	output wire [W-1:0] o_fall
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : lane
			reg meta_reg; // First stage, read only by second
			reg sync_reg; // Stable copy
			reg prev_reg; // Last cycle's stable copy
			// Synchroniser and history
			always @(posedge i_clk) begin
				if (i_rst) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					prev_reg <= 1'b0;
				end else begin
					meta_reg <= i_pins[g];
					sync_reg <= meta_reg;
					prev_reg <= sync_reg;
				end
			end
			// One pulse per edge
			assign o_rise[g] = sync_reg & ~prev_reg;
			assign o_fall[g] = ~sync_reg & prev_reg;
		end
	endgenerate
endmodule

// ---- hdl/tcc_toggle_ff.v ----
/*
 * Timer toggle flip-flop with software invert/set/clear field.
 * Assumes i_wr is a one-cycle write strobe and i_invert a one-cycle event.
 */
`timescale 1ns/10ps
`include "tcc_regs.vh"
module tcc_toggle_ff (
	input wire i_clk,
	input wire i_rst,
	input wire i_wr,
	input wire [1:0] i_field,
	input wire i_invert,
	output reg o_q
);
	// A software invert, set or clear write wins over a hardware invert in the same cycle; a no-change write does not
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_q <= 1'b0;
		end else if (i_wr && i_field == `TCC_TGL_INVERT) begin
			o_q <= ~o_q;
		end else if (i_wr && i_field == `TCC_TGL_SET) begin
			o_q <= 1'b1;
		end else if (i_wr && i_field == `TCC_TGL_CLEAR) begin
			o_q <= 1'b0;
		end else if (i_invert) begin
			o_q <= ~o_q;
		end
	end
endmodule

// ---- hdl/tcc_top.v ----
/*
 * One 16-bit timer/event counter channel with two compare and two
 * capture registers, toggle flip-flops and an APB register slave.
 * Assumes a single 100 MHz clock, synchronous active-high reset and
 * an APB master that holds each request until pready is seen.
 */
`timescale 1ns/10ps
`include "tcc_regs.vh"

module tcc_top #(
	parameter HAS_SECONDARY = 1
) (
	input wire I_MCLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire I_CAPTURE_INPUT_FIRST,
	input wire I_CAPTURE_INPUT_SECOND,
	input wire I_BYTE_TIMER_TOGGLE,
	output reg [31:0] O_PRDATA,
	output reg O_PREADY,
	output reg O_PSLVERR,
	output reg O_MATCH_A_IRQ,
	output reg O_MATCH_B_IRQ,
	output reg O_EDGE_IRQ_FIRST,
	output reg O_TIMER_OUTPUT_PIN,
	output reg O_SECONDARY_OUTPUT_PIN
);

	// Channel mode register
	reg run_reg; // Counter runs
	reg prescaler_run_reg; // Prescaler runs
	reg clear_en_reg; // Clear on compare B match
	reg [1:0] clock_select_field_reg; // Count source
	reg [1:0] capture_mode_sel_reg; // Capture timing
	reg double_buffer_en_reg; // Compare A double buffer
	reg pin_sel_reg; // Pin shows toggle, else port bit
	reg gpio_reg; // Port bit value when not timer

	// Toggle control register
	reg [3:0] invert_en_reg; // Cap B, cap A, match B, match A
	reg [1:0] sec_invert_en_reg; // Cap B, match B

	// Timer state
	reg [15:0] up_counter_reg; // The counter
	reg [15:0] up_counter_next;
	reg [15:0] compare_reg_a_reg; // Active compare A
	reg [15:0] compare_buf_a_reg; // Buffer behind compare A
	reg [15:0] compare_reg_b_reg; // Compare B
	reg [15:0] capture_reg_a_reg; // Capture A
	reg [15:0] capture_reg_b_reg; // Capture B
	reg [8:0] prescaler_reg; // Free divider
	reg eq_a_reg; // Last cycle's compare A equality
	reg eq_b_reg; // Last cycle's compare B equality

	// Bus decode
	wire bus_access = I_PSEL & I_PENABLE & O_PREADY;
	wire bus_write = bus_access & I_PWRITE;
	wire wr_ctrl = bus_write && I_PADDR == `TCC_OFF_CTRL;
	wire wr_toggle = bus_write && I_PADDR == `TCC_OFF_TOGGLE;
	wire wr_cmp_a = bus_write && I_PADDR == `TCC_OFF_CMP_A;
	wire wr_cmp_b = bus_write && I_PADDR == `TCC_OFF_CMP_B;
	reg [31:0] rd_data; // Read mux output
	reg rd_ok; // Address is mapped

	// Synchronised edges: 0 first pin, 1 second pin, 2 byte toggle
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;

	// Count, compare and capture events
	reg count_tick; // Selected count source ticks this cycle
	wire eq_a = up_counter_reg == compare_reg_a_reg;
	wire eq_b = up_counter_reg == compare_reg_b_reg;
	wire match_a_evt = eq_a & ~eq_a_reg;
	wire match_b_evt = eq_b & ~eq_b_reg;
	reg hw_cap_a; // Hardware capture into A
	reg hw_cap_b; // Hardware capture into B
	wire soft_cap = wr_ctrl & ~I_PWDATA[`TCC_CTRL_SOFT_CAP_N];
	wire cap_a_evt = hw_cap_a | soft_cap;
	wire edge_irq_evt;
	wire pri_invert;
	wire sec_invert;
	wire primary_toggle_ff;
	wire secondary_toggle_ff;

	// Input synchronisers; every edge lives exactly one cycle
	tcc_edge_sync #(
		.W(3)
	) u_sync (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_pins({I_BYTE_TIMER_TOGGLE, I_CAPTURE_INPUT_SECOND,
			I_CAPTURE_INPUT_FIRST}),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// APB handshake: one wait state, pready registered
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA <= `TCC_RST_WORD;
		end else begin
			// Ready goes high in the second access cycle only
			O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
			O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~rd_ok;
			if (I_PSEL & I_PENABLE & ~O_PREADY & ~I_PWRITE) begin
				O_PRDATA <= rd_data;
			end
		end
	end

	// Read mux; soft capture bit always reads 1
	always @* begin
		rd_data = `TCC_RST_WORD;
		rd_ok = 1'b1;
		case (I_PADDR)
			`TCC_OFF_CTRL: begin
				rd_data[`TCC_CTRL_RUN] = run_reg;
				rd_data[`TCC_CTRL_PRE_RUN] = prescaler_run_reg;
				rd_data[`TCC_CTRL_CLR_EN] = clear_en_reg;
				rd_data[`TCC_CTRL_CLK_HI:`TCC_CTRL_CLK_LO] =
					clock_select_field_reg;
				rd_data[`TCC_CTRL_CAP_HI:`TCC_CTRL_CAP_LO] =
					capture_mode_sel_reg;
				rd_data[`TCC_CTRL_SOFT_CAP_N] = 1'b1;
				rd_data[`TCC_CTRL_DB_EN] = double_buffer_en_reg;
				rd_data[`TCC_CTRL_PIN_SEL] = pin_sel_reg;
				rd_data[`TCC_CTRL_GPIO] = gpio_reg;
			end
			`TCC_OFF_TOGGLE: begin
				// Action fields read as no-change
				rd_data[`TCC_TGL_CTL_HI:`TCC_TGL_CTL_LO] = `TCC_TGL_KEEP;
				rd_data[`TCC_TGL_EN_HI:`TCC_TGL_EN_LO] = invert_en_reg;
				rd_data[`TCC_TGL_SEC_CTL_HI:`TCC_TGL_SEC_CTL_LO] =
					`TCC_TGL_KEEP;
				rd_data[`TCC_TGL_SEC_EN_HI:`TCC_TGL_SEC_EN_LO] =
					sec_invert_en_reg;
				rd_data[`TCC_TGL_PRI_STATE] = primary_toggle_ff;
				rd_data[`TCC_TGL_SEC_STATE] = secondary_toggle_ff;
			end
			`TCC_OFF_CMP_A: begin
				rd_data[15:0] = compare_reg_a_reg;
			end
			`TCC_OFF_CMP_B: begin
				rd_data[15:0] = compare_reg_b_reg;
			end
			`TCC_OFF_CAP_A: begin
				rd_data[15:0] = capture_reg_a_reg;
			end
			`TCC_OFF_CAP_B: begin
				rd_data[15:0] = capture_reg_b_reg;
			end
			`TCC_OFF_COUNT: begin
				rd_data[15:0] = up_counter_reg;
			end
			default: begin
				// Unmapped: zero data with an error
				rd_ok = 1'b0;
			end
		endcase
	end

	// Control registers written by software
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			run_reg <= 1'b0;
			prescaler_run_reg <= 1'b0;
			clear_en_reg <= 1'b0;
			clock_select_field_reg <= `TCC_CLK_EXT;
			capture_mode_sel_reg <= `TCC_CAP_OFF;
			double_buffer_en_reg <= 1'b0;
			pin_sel_reg <= 1'b0;
			gpio_reg <= 1'b0;
			invert_en_reg <= 4'h0;
			sec_invert_en_reg <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				run_reg <= I_PWDATA[`TCC_CTRL_RUN];
				prescaler_run_reg <= I_PWDATA[`TCC_CTRL_PRE_RUN];
				clear_en_reg <= I_PWDATA[`TCC_CTRL_CLR_EN];
				clock_select_field_reg <=
					I_PWDATA[`TCC_CTRL_CLK_HI:`TCC_CTRL_CLK_LO];
				capture_mode_sel_reg <=
					I_PWDATA[`TCC_CTRL_CAP_HI:`TCC_CTRL_CAP_LO];
				double_buffer_en_reg <= I_PWDATA[`TCC_CTRL_DB_EN];
				pin_sel_reg <= I_PWDATA[`TCC_CTRL_PIN_SEL];
				gpio_reg <= I_PWDATA[`TCC_CTRL_GPIO];
			end
			if (wr_toggle) begin
				invert_en_reg <=
					I_PWDATA[`TCC_TGL_EN_HI:`TCC_TGL_EN_LO];
				sec_invert_en_reg <=
					I_PWDATA[`TCC_TGL_SEC_EN_HI:`TCC_TGL_SEC_EN_LO];
			end
		end
	end

	// Prescaler; only advances while software lets it run
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			prescaler_reg <= 9'h000;
		end else if (prescaler_run_reg) begin
			prescaler_reg <= prescaler_reg + 9'h001;
		end
	end

	// Count source select
	always @* begin
		case (clock_select_field_reg)
			`TCC_CLK_EXT: count_tick = pin_rise[0];
			`TCC_CLK_T1: count_tick = prescaler_run_reg &&
				(prescaler_reg & `TCC_PRE_MASK_T1) == `TCC_PRE_MASK_T1;
			`TCC_CLK_T4: count_tick = prescaler_run_reg &&
				(prescaler_reg & `TCC_PRE_MASK_T4) == `TCC_PRE_MASK_T4;
			`TCC_CLK_T16: count_tick = prescaler_run_reg &&
				(prescaler_reg & `TCC_PRE_MASK_T16) == `TCC_PRE_MASK_T16;
			default: count_tick = 1'b0;
		endcase
	end

	// Counter next value; clear on match B beats a count
	always @* begin
		up_counter_next = up_counter_reg;
		if (clear_en_reg && match_b_evt) begin
			up_counter_next = 16'h0000;
		end else if (run_reg && count_tick) begin
			// Natural 16-bit wrap when clearing is off
			up_counter_next = up_counter_reg + 16'h0001;
		end
	end

	// Counter and match history
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			up_counter_reg <= 16'h0000;
			eq_a_reg <= 1'b0;
			eq_b_reg <= 1'b0;
		end else begin
			up_counter_reg <= up_counter_next;
			eq_a_reg <= eq_a;
			eq_b_reg <= eq_b;
		end
	end

	// Compare registers and the compare A buffer
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			compare_reg_a_reg <= `TCC_RST_CMP;
			compare_buf_a_reg <= `TCC_RST_CMP;
			compare_reg_b_reg <= `TCC_RST_CMP;
		end else begin
			if (wr_cmp_a) begin
				compare_buf_a_reg <= I_PWDATA[15:0];
			end
			if (wr_cmp_a && !double_buffer_en_reg) begin
				compare_reg_a_reg <= I_PWDATA[15:0];
			end else if (double_buffer_en_reg && match_b_evt) begin
				// Swap at period end avoids a torn duty cycle
				compare_reg_a_reg <= compare_buf_a_reg;
			end
			if (wr_cmp_b) begin
				compare_reg_b_reg <= I_PWDATA[15:0];
			end
		end
	end

	// Hardware capture timing per mode
	always @* begin
		case (capture_mode_sel_reg)
			`TCC_CAP_OFF: begin
				hw_cap_a = 1'b0;
				hw_cap_b = 1'b0;
			end
			`TCC_CAP_TWO_PIN: begin
				hw_cap_a = pin_rise[0];
				hw_cap_b = pin_rise[1];
			end
			`TCC_CAP_PULSE: begin
				hw_cap_a = pin_rise[0];
				hw_cap_b = pin_fall[0];
			end
			`TCC_CAP_BYTE_TGL: begin
				hw_cap_a = pin_rise[2];
				hw_cap_b = pin_fall[2];
			end
			default: begin
				hw_cap_a = 1'b0;
				hw_cap_b = 1'b0;
			end
		endcase
	end

	// Capture registers; merged request loads once
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			capture_reg_a_reg <= 16'h0000;
			capture_reg_b_reg <= 16'h0000;
		end else begin
			if (cap_a_evt) begin
				capture_reg_a_reg <= up_counter_reg;
			end
			if (hw_cap_b) begin
				capture_reg_b_reg <= up_counter_reg;
			end
		end
	end

	// Edge interrupt polarity follows the capture mode
	assign edge_irq_evt = (capture_mode_sel_reg == `TCC_CAP_PULSE) ?
		pin_fall[0] : pin_rise[0];

	// Invert requests for the two toggle flip-flops
	assign pri_invert = (invert_en_reg[0] & match_a_evt) |
		(invert_en_reg[1] & match_b_evt) |
		(invert_en_reg[2] & cap_a_evt) |
		(invert_en_reg[3] & hw_cap_b);
	assign sec_invert = (sec_invert_en_reg[0] & match_b_evt) |
		(sec_invert_en_reg[1] & hw_cap_b);

	// Primary toggle flip-flop
	tcc_toggle_ff u_primary (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_wr(wr_toggle),
		.i_field(I_PWDATA[`TCC_TGL_CTL_HI:`TCC_TGL_CTL_LO]),
		.i_invert(pri_invert),
		.o_q(primary_toggle_ff)
	);

	// Secondary toggle, held low on channels built with HAS_SECONDARY at 0 (default 1)
	tcc_toggle_ff u_secondary (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_wr(wr_toggle & (HAS_SECONDARY != 0)),
		.i_field(I_PWDATA[`TCC_TGL_SEC_CTL_HI:`TCC_TGL_SEC_CTL_LO]),
		.i_invert(sec_invert & (HAS_SECONDARY != 0)),
		.o_q(secondary_toggle_ff)
	);

	// Registered outputs: interrupts and pins
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			O_MATCH_A_IRQ <= 1'b0;
			O_MATCH_B_IRQ <= 1'b0;
			O_EDGE_IRQ_FIRST <= 1'b0;
			O_TIMER_OUTPUT_PIN <= 1'b0;
			O_SECONDARY_OUTPUT_PIN <= 1'b0;
		end else begin
			O_MATCH_A_IRQ <= match_a_evt;
			O_MATCH_B_IRQ <= match_b_evt;
			O_EDGE_IRQ_FIRST <= edge_irq_evt;
			// Pin shared with a port bit; one cycle late
			O_TIMER_OUTPUT_PIN <= pin_sel_reg ?
				primary_toggle_ff : gpio_reg;
			O_SECONDARY_OUTPUT_PIN <= secondary_toggle_ff;
		end
	end

endmodule

// ---- test/tcc_pin_drv.sv ----
/*
 * Far-side model: capture pins and the byte timer toggle line.
 * Assumes the bench calls its tasks one at a time from one process.
 */
`timescale 1ns/10ps
module tcc_pin_drv (
	input wire i_clk,
	output logic o_first,
	output logic o_second,
	output logic o_toggle
);
	// All lines idle low from time zero
	initial begin
		o_first = 1'b0;
		o_second = 1'b0;
		o_toggle = 1'b0;
	end

	// Pulse held four cycles, well above the synchroniser's minimum
	task automatic pulse(input logic sel);
		begin
			@(posedge i_clk);
			if (sel) begin
				o_second <= 1'b1;
			end else begin
				o_first <= 1'b1;
			end
			repeat (4) @(posedge i_clk);
			o_first <= 1'b0;
			o_second <= 1'b0;
			repeat (4) @(posedge i_clk);
		end
	endtask

	// New toggle level, then settle time for the capture
	task automatic set_tgl(input logic v);
		begin
			@(posedge i_clk);
			o_toggle <= v;
			repeat (6) @(posedge i_clk);
		end
	endtask
endmodule

// ---- test/tcc_top_chk.sv ----
/*
 * Port-level assertions for the timer channel top.
 * Assumes an APB master that holds each request until O_PREADY.
 */
`timescale 1ns/10ps
module tcc_top_chk (
	input wire I_MCLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire I_CAPTURE_INPUT_FIRST,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire O_MATCH_A_IRQ,
	input wire O_MATCH_B_IRQ,
	input wire O_EDGE_IRQ_FIRST
);
	reg [1:0] mode_reg; // Capture mode as last written
	wire wr_ctrl; // Completed write to the mode register
	assign wr_ctrl = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
		I_PADDR == 8'h00;

	// Shadow of the mode field, so edge polarity can be judged
	always @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			mode_reg <= 2'h0;
		end else if (wr_ctrl) begin
			mode_reg <= I_PWDATA[6:5];
		end
	end

	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_SYS_RST);

	a_ready_wait: assert property (I_PSEL && !I_PENABLE |=>
		!O_PREADY ##1 O_PREADY) else $error("ready not after one wait");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (O_PREADY |->
		I_PSEL && I_PENABLE && $past(I_PENABLE))
		else $error("ready without access phase");
	a_err_flag: assert property (O_PREADY && I_PADDR[1:0] == 2'h0 |->
		O_PSLVERR == (I_PADDR > 8'h18)) else $error("bad error flag");
	a_err_data: assert property (O_PREADY && O_PSLVERR && !I_PWRITE |->
		O_PRDATA == 32'h0000_0000) else $error("error read not zero");
	a_irq_a_once: assert property (O_MATCH_A_IRQ |=> !O_MATCH_A_IRQ)
		else $error("match a irq too long");
	a_irq_b_once: assert property (O_MATCH_B_IRQ |=> !O_MATCH_B_IRQ)
		else $error("match b irq too long");
	a_edge_rise: assert property ($rose(I_CAPTURE_INPUT_FIRST) &&
		mode_reg != 2'h2 |-> ##[2:6] O_EDGE_IRQ_FIRST)
		else $error("no edge irq after rise");
	a_edge_fall: assert property ($fell(I_CAPTURE_INPUT_FIRST) &&
		mode_reg == 2'h2 |-> ##[2:6] O_EDGE_IRQ_FIRST)
		else $error("no edge irq after fall");

	c_err: cover property (O_PREADY && O_PSLVERR);
	c_match_b: cover property (O_MATCH_B_IRQ);
	c_fall_irq: cover property (mode_reg == 2'h2 && O_EDGE_IRQ_FIRST);
endmodule

bind tcc_top tcc_top_chk i_chk (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
	.I_CAPTURE_INPUT_FIRST(I_CAPTURE_INPUT_FIRST), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .O_MATCH_A_IRQ(O_MATCH_A_IRQ),
	.O_MATCH_B_IRQ(O_MATCH_B_IRQ), .O_EDGE_IRQ_FIRST(O_EDGE_IRQ_FIRST));

// ---- test/tcc_top_tb.sv ----
/*
 * Self-checking bench for the timer channel: APB master, pin model
 * and a read scoreboard. Assumes the design and pin model are built.
 */
`timescale 1ns/10ps
`include "tcc_regs.vh"
module tcc_top_tb;
	logic mclk = 1'b0; // 100 MHz system clock
	logic sys_rst = 1'b1; // Held for four cycles
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	wire pin_a;
	wire pin_b;
	wire pin_t;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire irq_a;
	wire irq_b;
	wire irq_e;
	wire out_p;
	wire out_s;
	logic [32:0] exp_q[$]; // Expected {error, data} per read
	logic [32:0] cnt_a = 33'h0; // Irq pulse tallies
	logic [32:0] cnt_b = 33'h0;
	logic [32:0] cnt_e = 33'h0;
	logic [31:0] rnd = 32'h420f_b32c;
	logic [15:0] n; // Random event count
	logic [1:0] acts [0:3] = '{`TCC_TGL_SET, `TCC_TGL_CLEAR,
		`TCC_TGL_INVERT, `TCC_TGL_INVERT};
	logic tgl_exp [0:3] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int bad_count = 0;
	int total_checks = 0;

	always #5 mclk = ~mclk;

	tcc_top i_dut (.I_MCLK(mclk), .I_SYS_RST(sys_rst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .I_CAPTURE_INPUT_FIRST(pin_a),
		.I_CAPTURE_INPUT_SECOND(pin_b), .I_BYTE_TIMER_TOGGLE(pin_t),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_MATCH_A_IRQ(irq_a), .O_MATCH_B_IRQ(irq_b),
		.O_EDGE_IRQ_FIRST(irq_e), .O_TIMER_OUTPUT_PIN(out_p),
		.O_SECONDARY_OUTPUT_PIN(out_s));

	tcc_pin_drv i_pins (.i_clk(mclk), .o_first(pin_a),
		.o_second(pin_b), .o_toggle(pin_t));

	// Fixed-seed xorshift source
	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction

	// Single comparison point for every kind of result
	task automatic chk(input string nm, input logic [32:0] e,
		input logic [32:0] g);
		begin
			total_checks++;
			if (g !== e) begin
				bad_count++;
				$display("Error %s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	// One transfer; request stands until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		begin
			k = 0;
			@(posedge mclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge mclk);
			penable <= 1'b1;
			// Ready sampled at rising edges; release at that same edge
			do begin
				@(posedge mclk);
				k++;
			end while (pready !== 1'b1 && k < 50);
			if (pready !== 1'b1) begin
				// A slave that never answers counts as a mismatch
				bad_count++;
			end
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Read whose expected value goes to the scoreboard
	task automatic apb_rd(input logic [7:0] a, input logic [32:0] e);
		begin
			exp_q.push_back(e);
			apb(1'b0, a, 32'h0000_0000);
		end
	endtask

	// Monitor: read data and irq pulses, mid-cycle when settled
	always @(negedge mclk) begin
		if (pready === 1'b1 && psel && !pwrite) begin
			chk("read", exp_q.pop_front(), {pslverr, prdata});
		end
		if (irq_a === 1'b1) cnt_a = cnt_a + 33'h1;
		if (irq_b === 1'b1) cnt_b = cnt_b + 33'h1;
		if (irq_e === 1'b1) cnt_e = cnt_e + 33'h1;
	end

	// Verdict and end of run
	task automatic wrap_up();
		begin
			$display("checks %0d mismatches %0d", total_checks, bad_count);
			if (bad_count == 0 && total_checks > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		void'(xs());
		n = 16'h0001 + {13'h0, rnd[2:0]};
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		apb_rd(`TCC_OFF_CTRL, 33'h0_0000_0080);
		apb_rd(8'h1C, 33'h1_0000_0000);
		// Count pin events, then read them via software capture
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0083);
		for (int i = 0; i < n; i++) i_pins.pulse(1'b0);
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0003);
		apb_rd(`TCC_OFF_CAP_A, {17'h0, n});
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0083);
		i_pins.pulse(1'b1);
		apb_rd(`TCC_OFF_CAP_B, 33'h0);
		i_pins.pulse(1'b0);
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_00A3);
		i_pins.pulse(1'b1);
		apb_rd(`TCC_OFF_CAP_B, {17'h0, n + 16'h0001});
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_00C3);
		i_pins.pulse(1'b0);
		apb_rd(`TCC_OFF_CAP_B, {17'h0, n + 16'h0002});
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_00E3);
		i_pins.set_tgl(1'b1);
		apb_rd(`TCC_OFF_CAP_A, {17'h0, n + 16'h0002});
		i_pins.pulse(1'b0);
		i_pins.set_tgl(1'b0);
		apb_rd(`TCC_OFF_CAP_B, {17'h0, n + 16'h0003});
		apb(1'b1, `TCC_OFF_COUNT, 32'h0000_0005);
		apb_rd(`TCC_OFF_COUNT, {17'h0, n + 16'h0003});
		chk("edge irqs", {17'h0, n + 16'h0003}, cnt_e);
		// Second reset, then compare, clear and double buffer
		sys_rst <= 1'b1;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		apb_rd(`TCC_OFF_CMP_A, 33'h0);
		apb(1'b1, `TCC_OFF_CMP_A, 32'h0000_0002);
		apb(1'b1, `TCC_OFF_CMP_B, 32'h0000_0004);
		apb(1'b1, `TCC_OFF_TOGGLE, 32'h0000_018E);
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0387);
		apb(1'b1, `TCC_OFF_CMP_A, 32'h0000_0003);
		apb_rd(`TCC_OFF_CMP_A, 33'h2);
		cnt_a = 33'h0;
		cnt_b = 33'h0;
		for (int i = 0; i < 7; i++) i_pins.pulse(1'b0);
		chk("match a irqs", 33'h2, cnt_a);
		chk("match b irqs", 33'h1, cnt_b);
		apb_rd(`TCC_OFF_COUNT, 33'h3);
		apb_rd(`TCC_OFF_CMP_A, 33'h3);
		chk("primary pin", 33'h1, {32'h0, out_p});
		chk("secondary pin", 33'h1, {32'h0, out_s});
		// Software set, clear and invert of both toggles
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `TCC_OFF_TOGGLE, {24'h0, acts[i], 4'h0, acts[i]});
			repeat (3) @(negedge mclk);
			chk("primary pin", {32'h0, tgl_exp[i]}, {32'h0, out_p});
			chk("secondary pin", {32'h0, tgl_exp[i]}, {32'h0, out_s});
		end
		apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0483);
		repeat (3) @(negedge mclk);
		chk("gpio pin", 33'h1, {32'h0, out_p});
		wrap_up();
	end
endmodule
